//--- common/pcr_pkg.sv
package pcr_pkg;

   // ==========================================================
   // register offsets
   localparam logic [7:0] OFS_OVP = 8'h4F;
   localparam logic [7:0] OFS_UVP = 8'h50;
   localparam logic [7:0] OFS_TW = 8'h51;
   localparam logic [7:0] OFS_CLR = 8'h52;
   localparam logic [7:0] OFS_AUX = 8'h53;

   // ==========================================================
   // field positions
   localparam int BIT_CLR = 0;
   localparam int BIT_CURRENT_LIMIT_EVENT = 1;
   localparam int BIT_SRC = 2;
   localparam int BIT_ULT = 3;

   // ==========================================================
   // values after reset
   localparam logic [2:0] RST_OVP = 3'h0;
   localparam logic [2:0] RST_UVP = 3'h0;
   localparam logic [7:0] RST_TW = 8'hFF;
   localparam logic RST_CLR = 1'h0;
   localparam logic RST_ULT = 1'h0;
   localparam logic RST_SRC = 1'h0;
   localparam logic RST_CURRENT_LIMIT_EVENT = 1'h0;
   localparam logic RST_PIN = 1'h1;

   // ==========================================================
   // threshold coding and serial bus constants
   localparam logic [2:0] CODE_SPECIAL = 3'h4;
   localparam logic [8:0] STEP_MV = 9'h032;
   localparam logic [2:0] BIT_LAST = 3'h7;
   // arbitrary bus address
   localparam logic [6:0] DEV_ADDR = 7'h2A;

   // ==========================================================
   // types
   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_REG, ST_WR, ST_ACK, ST_RD, ST_RACK
   } pcr_state_t;

   typedef struct packed {
      logic [2:0] ovp_code;
      logic [2:0] uvp_code;
      logic [7:0] warn_thr;
      logic ult_en;
      logic src_bus;
      logic current_limit_trigger_select;
   } pcr_cfg_t;

   typedef struct packed {
      logic signed [8:0] offset_mv;
      logic special;
   } pcr_thr_t;

endpackage : pcr_pkg

//--- core/pcr_sync2.sv
`timescale 1ns/100ps
module pcr_sync2 #(
   parameter logic RST_VAL = 1'b1
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic din,
   output logic dout
);

   logic meta_ff;
   logic sync_ff;

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         meta_ff <= RST_VAL;
         sync_ff <= RST_VAL;
      end
      else
      begin
         meta_ff <= din;
         sync_ff <= meta_ff;
      end
   end

   assign dout = sync_ff;

endmodule : pcr_sync2

//--- core/pcr_thr_decode.sv
`timescale 1ns/100ps
module pcr_thr_decode #(
   parameter bit INVERT = 1'b0
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [2:0] code,
   output pcr_pkg::pcr_thr_t thr
);

   // ==========================================================
   // code to signed offset in mV
   logic [8:0] mag_mv;
   logic neg;
   logic special;
   logic [8:0] nxt_raw;
   pcr_pkg::pcr_thr_t thr_ff;

   assign mag_mv = 9'(code[1:0]) * pcr_pkg::STEP_MV;
   assign neg = code[2] ^ INVERT;
   assign special = (code == pcr_pkg::CODE_SPECIAL);
   assign nxt_raw = special ? 9'h000 : neg ? 9'(~mag_mv + 9'h001) : mag_mv;

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         thr_ff <= '0;
      end
      else
      begin
         thr_ff.offset_mv <= $signed(nxt_raw);
         thr_ff.special <= special;
      end
   end

   assign thr = thr_ff;

   // ==========================================================
   // checks
   property p_one_step;
      @(posedge mclk) disable iff (rst)
      code == 3'h1 |=>
         thr.offset_mv == (INVERT ? -9'sh032 : 9'sh032);
   endproperty
   a_one_step: assert property (p_one_step)
      else $error("one-step code gives wrong offset");

   property p_special;
      @(posedge mclk) disable iff (rst)
      code == 3'h4 |=> thr.special && thr.offset_mv == 9'sh000;
   endproperty
   a_special: assert property (p_special)
      else $error("special code not flagged");

endmodule : pcr_thr_decode

//--- core/pcr_top.sv
`timescale 1ns/100ps
module pcr_top (
   input wire logic mclk,
   input wire logic rst,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic reg_lock,
   output pcr_pkg::pcr_cfg_t cfg,
   output pcr_pkg::pcr_thr_t ovp_thr,
   output pcr_pkg::pcr_thr_t uvp_thr,
   output logic ocp_status_clear
);

   // ==========================================================
   // pin synchronisers and line events
   logic scl_s;
   logic sda_s;
   logic scl_d_ff;
   logic sda_d_ff;
   logic rise;
   logic fall;
   logic start;
   logic stop;

   pcr_sync2 #(.RST_VAL(pcr_pkg::RST_PIN)) u_sync_scl (
      .mclk(mclk),
      .rst(rst),
      .din(scl_in),
      .dout(scl_s)
   );

   pcr_sync2 #(.RST_VAL(pcr_pkg::RST_PIN)) u_sync_sda (
      .mclk(mclk),
      .rst(rst),
      .din(sda_in),
      .dout(sda_s)
   );

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         scl_d_ff <= pcr_pkg::RST_PIN;
         sda_d_ff <= pcr_pkg::RST_PIN;
      end
      else
      begin
         scl_d_ff <= scl_s;
         sda_d_ff <= sda_s;
      end
   end

   assign rise = ~scl_d_ff & scl_s;
   assign fall = scl_d_ff & ~scl_s;
   assign start = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
   assign stop = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

   // ==========================================================
   // serial slave state
   pcr_pkg::pcr_state_t st_ff;
   pcr_pkg::pcr_state_t nxt_st;
   pcr_pkg::pcr_state_t tgt_ff;
   pcr_pkg::pcr_state_t nxt_tgt;
   logic [2:0] bit_ff;
   logic [2:0] nxt_bit;
   logic [7:0] sh_ff;
   logic [7:0] nxt_sh;
   logic [7:0] ptr_ff;
   logic [7:0] nxt_ptr;
   logic full_ff;
   logic nxt_full;
   logic sda_oe_ff;
   logic nxt_oe;
   logic sda_out_ff;
   logic [7:0] rd_data;

   always_comb
   begin
      nxt_st = st_ff;
      nxt_tgt = tgt_ff;
      nxt_bit = bit_ff;
      nxt_sh = sh_ff;
      nxt_ptr = ptr_ff;
      nxt_full = full_ff;
      nxt_oe = sda_oe_ff;
      if (stop)
      begin
         nxt_st = pcr_pkg::ST_IDLE;
         nxt_oe = 1'b0;
      end
      else if (start)
      begin
         nxt_st = pcr_pkg::ST_ADDR;
         nxt_bit = 3'h0;
         nxt_full = 1'b0;
         nxt_oe = 1'b0;
      end
      else if (rise)
      begin
         case (st_ff)
            pcr_pkg::ST_ADDR, pcr_pkg::ST_REG, pcr_pkg::ST_WR:
            begin
               nxt_sh = {sh_ff[6:0], sda_s};
               nxt_bit = bit_ff + 3'h1;
               nxt_full = (bit_ff == pcr_pkg::BIT_LAST);
            end
            pcr_pkg::ST_RACK:
            begin
               // master nack ends the read
               nxt_st = sda_s ? pcr_pkg::ST_IDLE : pcr_pkg::ST_ACK;
            end
            default:
            begin
            end
         endcase
      end
      else if (fall)
      begin
         case (st_ff)
            pcr_pkg::ST_ADDR:
            begin
               if (full_ff)
               begin
                  nxt_full = 1'b0;
                  if (sh_ff[7:1] == pcr_pkg::DEV_ADDR)
                  begin
                     nxt_oe = 1'b1;
                     nxt_st = pcr_pkg::ST_ACK;
                     nxt_tgt = sh_ff[0] ? pcr_pkg::ST_RD
                                        : pcr_pkg::ST_REG;
                  end
                  else
                  begin
                     nxt_st = pcr_pkg::ST_IDLE;
                  end
               end
            end
            pcr_pkg::ST_REG:
            begin
               if (full_ff)
               begin
                  nxt_full = 1'b0;
                  nxt_ptr = sh_ff;
                  nxt_oe = 1'b1;
                  nxt_st = pcr_pkg::ST_ACK;
                  nxt_tgt = pcr_pkg::ST_WR;
               end
            end
            pcr_pkg::ST_WR:
            begin
               if (full_ff)
               begin
                  nxt_full = 1'b0;
                  nxt_ptr = ptr_ff + 8'h01;
                  nxt_oe = 1'b1;
                  nxt_st = pcr_pkg::ST_ACK;
               end
            end
            pcr_pkg::ST_ACK:
            begin
               if (tgt_ff == pcr_pkg::ST_RD)
               begin
                  nxt_sh = rd_data;
                  nxt_oe = ~rd_data[7];
                  nxt_bit = 3'h1;
                  nxt_ptr = ptr_ff + 8'h01;
                  nxt_st = pcr_pkg::ST_RD;
               end
               else
               begin
                  nxt_oe = 1'b0;
                  nxt_bit = 3'h0;
                  nxt_st = tgt_ff;
               end
            end
            pcr_pkg::ST_RD:
            begin
               if (bit_ff == 3'h0)
               begin
                  nxt_oe = 1'b0;
                  nxt_st = pcr_pkg::ST_RACK;
               end
               else
               begin
                  nxt_sh = {sh_ff[6:0], 1'b0};
                  nxt_oe = ~sh_ff[6];
                  nxt_bit = bit_ff + 3'h1;
               end
            end
            default:
            begin
            end
         endcase
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         st_ff <= pcr_pkg::ST_IDLE;
         tgt_ff <= pcr_pkg::ST_IDLE;
         bit_ff <= 3'h0;
         sh_ff <= 8'h00;
         ptr_ff <= 8'h00;
         full_ff <= 1'b0;
         sda_oe_ff <= 1'b0;
         sda_out_ff <= 1'b0;
      end
      else
      begin
         st_ff <= nxt_st;
         tgt_ff <= nxt_tgt;
         bit_ff <= nxt_bit;
         sh_ff <= nxt_sh;
         ptr_ff <= nxt_ptr;
         full_ff <= nxt_full;
         sda_oe_ff <= nxt_oe;
         sda_out_ff <= 1'b0;
      end
   end

   // ==========================================================
   // register write decode
   logic wr_stb;
   logic wr_ovp;
   logic wr_uvp;
   logic wr_tw;
   logic wr_clr;
   logic wr_aux;
   logic clr_rise;

   assign wr_stb = fall & full_ff & (st_ff == pcr_pkg::ST_WR);
   assign wr_ovp = wr_stb & ~reg_lock & (ptr_ff == pcr_pkg::OFS_OVP);
   assign wr_uvp = wr_stb & ~reg_lock & (ptr_ff == pcr_pkg::OFS_UVP);
   assign wr_tw = wr_stb & ~reg_lock & (ptr_ff == pcr_pkg::OFS_TW);
   assign wr_aux = wr_stb & ~reg_lock & (ptr_ff == pcr_pkg::OFS_AUX);
   assign wr_clr = wr_stb & (ptr_ff == pcr_pkg::OFS_CLR);

   // ==========================================================
   // configuration registers
   pcr_pkg::pcr_cfg_t cfg_ff;
   logic clr_ff;
   logic ocp_clr_ff;

   assign clr_rise = wr_clr & sh_ff[pcr_pkg::BIT_CLR] & ~clr_ff;

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         cfg_ff.ovp_code <= pcr_pkg::RST_OVP;
         cfg_ff.uvp_code <= pcr_pkg::RST_UVP;
         cfg_ff.warn_thr <= pcr_pkg::RST_TW;
         cfg_ff.ult_en <= pcr_pkg::RST_ULT;
         cfg_ff.src_bus <= pcr_pkg::RST_SRC;
         cfg_ff.current_limit_trigger_select <= pcr_pkg::RST_CURRENT_LIMIT_EVENT;
         clr_ff <= pcr_pkg::RST_CLR;
         ocp_clr_ff <= 1'b0;
      end
      else
      begin
         if (wr_ovp)
         begin
            cfg_ff.ovp_code <= sh_ff[2:0];
         end
         if (wr_uvp)
         begin
            cfg_ff.uvp_code <= sh_ff[2:0];
         end
         if (wr_tw)
         begin
            cfg_ff.warn_thr <= sh_ff;
         end
         if (wr_aux)
         begin
            cfg_ff.ult_en <= sh_ff[pcr_pkg::BIT_ULT];
            cfg_ff.src_bus <= sh_ff[pcr_pkg::BIT_SRC];
            cfg_ff.current_limit_trigger_select <= sh_ff[pcr_pkg::BIT_CURRENT_LIMIT_EVENT];
         end
         if (wr_clr)
         begin
            clr_ff <= sh_ff[pcr_pkg::BIT_CLR];
         end
         ocp_clr_ff <= clr_rise;
      end
   end

   // ==========================================================
   // read-back, reserved bits zero
   assign rd_data =
      (ptr_ff == pcr_pkg::OFS_OVP) ? {5'h00, cfg_ff.ovp_code} :
      (ptr_ff == pcr_pkg::OFS_UVP) ? {5'h00, cfg_ff.uvp_code} :
      (ptr_ff == pcr_pkg::OFS_TW) ? cfg_ff.warn_thr :
      (ptr_ff == pcr_pkg::OFS_CLR) ? {7'h00, clr_ff} :
      (ptr_ff == pcr_pkg::OFS_AUX) ?
         {4'h0, cfg_ff.ult_en, cfg_ff.src_bus, cfg_ff.current_limit_trigger_select, 1'b0} :
      8'h00;

   // ==========================================================
   // threshold decoders
   pcr_thr_decode #(.INVERT(1'b0)) u_ovp_dec (
      .mclk(mclk),
      .rst(rst),
      .code(cfg_ff.ovp_code),
      .thr(ovp_thr)
   );

   pcr_thr_decode #(.INVERT(1'b1)) u_uvp_dec (
      .mclk(mclk),
      .rst(rst),
      .code(cfg_ff.uvp_code),
      .thr(uvp_thr)
   );

   assign cfg = cfg_ff;
   assign ocp_status_clear = ocp_clr_ff;
   assign sda_oe = sda_oe_ff;
   assign sda_out = sda_out_ff;

   // ==========================================================
   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   sequence s_clr_edge;
      wr_clr && sh_ff[0] && !clr_ff;
   endsequence

   property p_ovp_wr;
      wr_ovp |=> cfg.ovp_code == $past(sh_ff[2:0]);
   endproperty
   a_ovp_wr: assert property (p_ovp_wr)
      else $error("over-voltage code not stored");

   property p_uvp_wr;
      wr_uvp |=> cfg.uvp_code == $past(sh_ff[2:0]);
   endproperty
   a_uvp_wr: assert property (p_uvp_wr)
      else $error("under-voltage code not stored");

   property p_tw_wr;
      wr_tw |=> cfg.warn_thr == $past(sh_ff);
   endproperty
   a_tw_wr: assert property (p_tw_wr)
      else $error("warning threshold not stored");

   property p_clr_pulse;
      s_clr_edge |=> ocp_status_clear ##1 !ocp_status_clear;
   endproperty
   a_clr_pulse: assert property (p_clr_pulse)
      else $error("clear edge gave no single pulse");

   property p_clr_locked;
      wr_clr && reg_lock |=> clr_ff == $past(sh_ff[0]);
   endproperty
   a_clr_locked: assert property (p_clr_locked)
      else $error("clear write refused under lock");

   property p_no_rearm;
      ocp_status_clear |-> clr_ff && !$past(clr_ff);
   endproperty
   a_no_rearm: assert property (p_no_rearm)
      else $error("clear pulse without 0 to 1 change");

   property p_aux_wr;
      wr_aux |=>
         {cfg.ult_en, cfg.src_bus, cfg.current_limit_trigger_select} == $past(sh_ff[3:1]);
   endproperty
   a_aux_wr: assert property (p_aux_wr)
      else $error("auxiliary bits not stored");

   property p_rsvd_rd;
      (fall && st_ff == pcr_pkg::ST_ACK && tgt_ff == pcr_pkg::ST_RD
       && (ptr_ff == 8'h4F || ptr_ff == 8'h50)) |=> sh_ff[7:3] == 5'h00;
   endproperty
   a_rsvd_rd: assert property (p_rsvd_rd)
      else $error("reserved bits read non-zero");

endmodule : pcr_top

//--- testbench/pcr_host_model.sv
`timescale 1ns/100ps
// ==========================================================
// serial bus host at the pins
module pcr_host_model (
   input wire logic mclk,
   input wire logic sda_oe,
   input wire logic sda_out,
   output logic scl,
   output logic sda
);
   logic drv_low;

   // open drain with pull-up: released line reads high
   assign sda = ~(drv_low | (sda_oe & ~sda_out));

   initial
   begin
      scl = 1'b1;
      drv_low = 1'b0;
   end

   // ==========================================================
   // bus phases, each step on a falling mclk edge
   task automatic half();
      repeat (6) @(negedge mclk);
   endtask : half

   // also serves as repeated start
   task automatic start();
      drv_low = 1'b0;
      half();
      scl = 1'b1;
      half();
      drv_low = 1'b1;
      half();
      scl = 1'b0;
   endtask : start

   task automatic stop();
      drv_low = 1'b1;
      half();
      scl = 1'b1;
      half();
      drv_low = 1'b0;
      half();
   endtask : stop

   // data held over the whole high phase, sampled before scl falls
   task automatic bit_io(input logic b, output logic s);
      drv_low = ~b;
      half();
      scl = 1'b1;
      half();
      s = sda;
      scl = 1'b0;
   endtask : bit_io

   // send wr (all ones to read), then ack slot driven by ack_in
   task automatic xfer(input logic [7:0] wr, input logic ack_in,
                       output logic [7:0] rd, output logic ack);
      for (int i = 7; i >= 0; i--)
         bit_io(wr[i], rd[i]);
      bit_io(ack_in, ack);
   endtask : xfer
endmodule : pcr_host_model

//--- testbench/testbench.sv
`timescale 1ns/100ps
module testbench;
   logic mclk;
   logic rst;
   logic reg_lock;
   logic scl;
   logic sda;
   logic sda_out;
   logic sda_oe;
   pcr_pkg::pcr_cfg_t cfg;
   pcr_pkg::pcr_thr_t ovp_thr;
   pcr_pkg::pcr_thr_t uvp_thr;
   logic ocp_status_clear;
   int n_fail = 0;
   int cmp_count = 0;
   int n_pulse = 0;
   logic [7:0] rd;
   logic ack;

   pcr_top pcr_top_inst (
      .mclk(mclk), .rst(rst), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe(sda_oe), .reg_lock(reg_lock),
      .cfg(cfg), .ovp_thr(ovp_thr), .uvp_thr(uvp_thr),
      .ocp_status_clear(ocp_status_clear)
   );

   pcr_host_model pcr_host_model_inst (
      .mclk(mclk), .sda_oe(sda_oe), .sda_out(sda_out),
      .scl(scl), .sda(sda)
   );

   initial
   begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   // counts clock cycles with the clear pulse high
   always @(negedge mclk)
   begin
      if (ocp_status_clear === 1'b1)
         n_pulse++;
   end

   // ==========================================================
   // compare and bus tasks
   task automatic check(input string what, input logic [9:0] exp,
                        input logic [9:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic wr_reg(input logic [7:0] ofs, input logic [7:0] d);
      pcr_host_model_inst.start();
      pcr_host_model_inst.xfer({pcr_pkg::DEV_ADDR, 1'b0}, 1'b1, rd, ack);
      check("address ack", 10'h000, 10'(ack));
      pcr_host_model_inst.xfer(ofs, 1'b1, rd, ack);
      pcr_host_model_inst.xfer(d, 1'b1, rd, ack);
      check("data ack", 10'h000, 10'(ack));
      pcr_host_model_inst.stop();
   endtask : wr_reg

   task automatic rd_reg(input logic [7:0] ofs, input logic [7:0] exp);
      pcr_host_model_inst.start();
      pcr_host_model_inst.xfer({pcr_pkg::DEV_ADDR, 1'b0}, 1'b1, rd, ack);
      pcr_host_model_inst.xfer(ofs, 1'b1, rd, ack);
      pcr_host_model_inst.start();
      pcr_host_model_inst.xfer({pcr_pkg::DEV_ADDR, 1'b1}, 1'b1, rd, ack);
      pcr_host_model_inst.xfer(8'hFF, 1'b1, rd, ack);
      pcr_host_model_inst.stop();
      check($sformatf("register %h", ofs), 10'(exp), 10'(rd));
   endtask : rd_reg

   // every code with reserved bits set; inv selects the under-voltage side
   task automatic thr_loop(input logic [7:0] ofs, input logic inv);
      logic [8:0] mv;
      pcr_pkg::pcr_thr_t t;
      for (int c = 0; c < 8; c++)
      begin
         wr_reg(ofs, {5'h1F, 3'(c)});
         t = inv ? uvp_thr : ovp_thr;
         mv = pcr_pkg::STEP_MV * 9'(c % 4);
         if ((c > 4) != inv)
            mv = -mv;
         check("code", 10'(c), 10'(inv ? cfg.uvp_code : cfg.ovp_code));
         check("threshold", {mv, 1'(c == 4)}, 10'(t));
         rd_reg(ofs, 8'(c));
      end
   endtask : thr_loop

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : complete_run

   // ==========================================================
   // tests
   initial
   begin
      rst = 1'b1;
      reg_lock = 1'b0;
      repeat (12) @(negedge mclk);
      rst = 1'b0;
      repeat (4) @(negedge mclk);
      check("cfg reset", 10'h3F8, 10'(cfg));
      check("cfg reset codes", 10'h001, 10'(cfg[16:10]));
      check("ovp reset", 10'h000, ovp_thr);
      check("uvp reset", 10'h000, uvp_thr);
      rd_reg(pcr_pkg::OFS_OVP, 8'h00);
      rd_reg(pcr_pkg::OFS_UVP, 8'h00);
      rd_reg(pcr_pkg::OFS_TW, 8'hFF);
      rd_reg(pcr_pkg::OFS_CLR, 8'h00);
      rd_reg(pcr_pkg::OFS_AUX, 8'h00);
      thr_loop(pcr_pkg::OFS_OVP, 1'b0);
      thr_loop(pcr_pkg::OFS_UVP, 1'b1);
      wr_reg(pcr_pkg::OFS_TW, 8'h5A);
      check("warning", 10'h05A, 10'(cfg.warn_thr));
      rd_reg(pcr_pkg::OFS_TW, 8'h5A);
      wr_reg(pcr_pkg::OFS_AUX, 8'hF8);
      check("aux", 10'h004, 10'({cfg.ult_en, cfg.src_bus, cfg.current_limit_trigger_select}));
      rd_reg(pcr_pkg::OFS_AUX, 8'h08);
      wr_reg(pcr_pkg::OFS_AUX, 8'h06);
      check("aux", 10'h003, 10'({cfg.ult_en, cfg.src_bus, cfg.current_limit_trigger_select}));
      rd_reg(pcr_pkg::OFS_AUX, 8'h06);
      wr_reg(pcr_pkg::OFS_CLR, 8'h01);
      check("clear pulses", 10'h001, 10'(n_pulse));
      wr_reg(pcr_pkg::OFS_CLR, 8'h01);
      check("clear pulses", 10'h001, 10'(n_pulse));
      wr_reg(pcr_pkg::OFS_CLR, 8'h00);
      reg_lock = 1'b1;
      wr_reg(pcr_pkg::OFS_CLR, 8'hFF);
      check("clear pulses", 10'h002, 10'(n_pulse));
      rd_reg(pcr_pkg::OFS_CLR, 8'h01);
      wr_reg(pcr_pkg::OFS_OVP, 8'h03);
      check("locked code", 10'h007, 10'(cfg.ovp_code));
      reg_lock = 1'b0;
      wr_reg(8'h60, 8'hAA);
      rd_reg(8'h60, 8'h00);
      // two-byte read with master ack between bytes
      pcr_host_model_inst.start();
      pcr_host_model_inst.xfer({pcr_pkg::DEV_ADDR, 1'b0}, 1'b1, rd, ack);
      pcr_host_model_inst.xfer(pcr_pkg::OFS_TW, 1'b1, rd, ack);
      pcr_host_model_inst.start();
      pcr_host_model_inst.xfer({pcr_pkg::DEV_ADDR, 1'b1}, 1'b1, rd, ack);
      pcr_host_model_inst.xfer(8'hFF, 1'b0, rd, ack);
      check("burst first", 10'h05A, 10'(rd));
      pcr_host_model_inst.xfer(8'hFF, 1'b1, rd, ack);
      check("burst second", 10'h001, 10'(rd));
      pcr_host_model_inst.stop();
      // reset again in mid-run with the bus idle
      rst = 1'b1;
      repeat (2) @(negedge mclk);
      rst = 1'b0;
      repeat (4) @(negedge mclk);
      check("cfg rerun", 10'h3F8, 10'(cfg));
      check("cfg rerun codes", 10'h001, 10'(cfg[16:10]));
      rd_reg(pcr_pkg::OFS_CLR, 8'h00);
      pcr_host_model_inst.start();
      pcr_host_model_inst.xfer(8'h22, 1'b1, rd, ack);
      check("foreign address", 10'h001, 10'(ack));
      pcr_host_model_inst.stop();
      complete_run();
   end

   // about twice the expected run length
   initial
   begin
      #400000;
      n_fail++;
      complete_run();
   end
endmodule : testbench
